/* File: gdp_defs.svh */
`ifndef GDP_DEFS_SVH
`define GDP_DEFS_SVH
// i/o port addresses
`define GDP_PORT_INDEX 16'h03CE
`define GDP_PORT_DATA 16'h03CF
// internal register indices
`define GDP_IDX_FILL 4'h0
`define GDP_IDX_FILL_EN 4'h1
`define GDP_IDX_CMP 4'h2
`define GDP_IDX_ROT 4'h3
`define GDP_IDX_RDMAP 4'h4
`define GDP_IDX_MODE 4'h5
`define GDP_IDX_MISC 4'h6
`define GDP_IDX_IGN 4'h7
`define GDP_IDX_MASK 4'h8
// field positions
`define GDP_ROT_LSB 0
`define GDP_FN_LSB 3
`define GDP_WM_LSB 0
`define GDP_RM_BIT 3
`define GDP_HOE_BIT 4
`define GDP_GFX_BIT 0
`define GDP_OE_BIT 1
`define GDP_WIN_LSB 2
// reset values
`define GDP_RST_BYTE 8'h00
`define GDP_RST_MASK 8'hFF
// memory windows, upper address bits a[19:15]
`define GDP_WIN_A0 5'h14
`define GDP_WIN_B0 5'h16
`define GDP_WIN_B8 5'h17
`endif

/* File: gdp_pkg.sv */
package gdp_pkg;
    typedef enum logic [1:0] {GDP_FN_PASS = 2'b00, GDP_FN_AND = 2'b01, GDP_FN_OR = 2'b10,
        GDP_FN_XOR = 2'b11} gdp_fn_e;
    typedef enum logic [1:0] {GDP_WM0 = 2'b00, GDP_WM1 = 2'b01, GDP_WM2 = 2'b10,
        GDP_WM3 = 2'b11} gdp_wm_e;
    // one byte per map
    typedef logic [3:0][7:0] gdp_maps_t;
    // a processor i/o cycle
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] data;
    } gdp_io_s;
    // a processor memory cycle
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [19:0] addr;
        logic [7:0] data;
    } gdp_mem_s;
endpackage

/* File: gdp_map_lane.sv */
`timescale 1ns/100ps
`include "gdp_defs.svh"
// one map's write path: source select, logical function, bit mask
module gdp_map_lane
(
    // controls
    input wire logic [1:0] write_mode_sel,
    input wire logic [1:0] logic_function,
    input wire logic fill_bit,
    input wire logic fill_en,
    input wire logic [7:0] write_bit_mask_value,
    // data
    input wire logic [7:0] rotated,
    input wire logic cpu_bit,
    input wire logic [7:0] latch,
    output logic [7:0] result
);
    import gdp_pkg::*;
    logic [7:0] src;  // source before function
    logic [7:0] fnout;  // after logical function
    logic [7:0] msk;  // effective mask
    // source select, function, mask combined
    always_comb
    begin
        src = rotated;
        msk = write_bit_mask_value;
        unique case (gdp_wm_e'(write_mode_sel))
            GDP_WM0: src = fill_en ? {8{fill_bit}} : rotated;
            GDP_WM1: src = latch;
            GDP_WM2: src = {8{cpu_bit}};
            GDP_WM3:
            begin
                src = {8{fill_bit}};
                msk = rotated & write_bit_mask_value;
            end
        endcase
        // function against latches; mode 3 applies it to the fill value too
        unique case (gdp_fn_e'(logic_function))
            GDP_FN_PASS: fnout = src;
            GDP_FN_AND: fnout = src & latch;
            GDP_FN_OR: fnout = src | latch;
            GDP_FN_XOR: fnout = src ^ latch;
        endcase
        // mode 1 copies the latches back untouched: no function, no mask
        if (write_mode_sel == 2'b01)
        begin
            fnout = src;
            msk = 8'hFF;
        end
        result = (fnout & msk) | (latch & ~msk);
    end
endmodule

/* File: gdp_core.sv */
`timescale 1ns/100ps
`include "gdp_defs.svh"
// What this block does
// - index port picks register behind data port
// - mode 0 enabled: fill bit fills map
// - mode 0 disabled: map takes processor data
// - fill enables ignored in modes 1-3
// - fill value used in mode 3
// - rotate right only in modes 0, 3
// - function: pass, and, or, xor
// - rotate, then function, then mask
// - mask picks new or latched bit
// - every read loads all four latches
// - read mode 0 returns selected map latch
// - chain four uses a1:a0 as map
// - read mode 1 compares pixels to colour
// - ignore bit zero drops map from compare
// - graphics bit selects serialize or bypass
// - odd/even swaps a0 for high bit
// - window field decodes display buffer range
module gdp_core
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // processor i/o cycle
    input wire gdp_pkg::gdp_io_s io_req,
    output logic [7:0] io_rdata,
    output logic io_hit,
    // processor memory cycle
    input wire gdp_pkg::gdp_mem_s mem_req,
    output logic mem_hit,
    output logic [7:0] mem_rdata,
    // sequencer state
    input wire logic chain_four,
    // display memory port
    output logic [15:0] vm_addr,
    output logic [3:0] vm_we,
    output gdp_pkg::gdp_maps_t vm_wdata,
    output logic vm_rd,
    input wire gdp_pkg::gdp_maps_t vm_rdata,
    input wire logic vm_rvalid,
    // display side
    output logic graphics_not_text,
    output logic host_odd_even_mode
);
    import gdp_pkg::*;
    logic [3:0] idx_q, idx_d;  // gfx_register_index
    logic [3:0] fill_q, fill_d;  // map_fill_bits
    logic [3:0] fen_q, fen_d;  // map_fill_enables
    logic [3:0] cmp_q, cmp_d;  // compare_colour
    logic [7:0] rot_q, rot_d;  // rotate count and function
    logic [1:0] rdmap_q, rdmap_d;  // read_plane
    logic [7:0] mode_q, mode_d;  // access mode control
    logic [7:0] misc_q, misc_d;  // display misc control
    logic [3:0] ign_q, ign_d;  // compare_ignore
    logic [7:0] bmask_q, bmask_d;  // write_bit_mask_value
    gdp_maps_t lat_q, lat_d;  // per-map data latches
    logic [7:0] rdat_q, rdat_d;  // data returned on memory read
    logic [1:0] rsel_q, rsel_d;  // map chosen at read time
    logic [7:0] iodat_q, iodat_d;  // i/o read data
    logic [1:0] write_mode_sel;
    logic read_mode_sel;
    logic [2:0] rotate_count;
    logic [1:0] logic_function;
    logic chain_odd_even;
    logic [1:0] memory_window_sel;
    logic [7:0] rotated;
    logic [15:0] off;  // offset inside window
    gdp_maps_t lane_out;
    logic [7:0] cmp_byte;

    assign write_mode_sel = mode_q[`GDP_WM_LSB +: 2];
    assign read_mode_sel = mode_q[`GDP_RM_BIT];
    assign rotate_count = rot_q[`GDP_ROT_LSB +: 3];
    assign logic_function = rot_q[`GDP_FN_LSB +: 2];
    assign chain_odd_even = misc_q[`GDP_OE_BIT];
    assign memory_window_sel = misc_q[`GDP_WIN_LSB +: 2];
    assign graphics_not_text = misc_q[`GDP_GFX_BIT];
    assign host_odd_even_mode = mode_q[`GDP_HOE_BIT];

    // window decode; 128k window spans a0000-bffff
    always_comb
    begin
        mem_hit = 1'b0;
        off = mem_req.addr[15:0];
        unique case (memory_window_sel)
            2'b00: mem_hit = mem_req.addr[19:17] == 3'b101;
            2'b01: mem_hit = mem_req.addr[19:16] == 4'hA;
            2'b10: mem_hit = mem_req.addr[19:15] == `GDP_WIN_B0;
            2'b11: mem_hit = mem_req.addr[19:15] == `GDP_WIN_B8;
        endcase
        if (memory_window_sel[1])
        begin
            off = {1'b0, mem_req.addr[14:0]};
        end
    end

    // address to maps; odd/even swaps a0 for a high bit
    always_comb
    begin
        vm_addr = off;
        if (chain_odd_even)
        begin
            vm_addr = {1'b0, off[15:1]};
            vm_addr[0] = memory_window_sel == 2'b00 ? mem_req.addr[16] : off[15];
        end
        else if (chain_four)
        begin
            vm_addr = {2'b00, off[15:2]};
        end
    end

    // rotation only in modes 0 and 3
    always_comb
    begin
        rotated = mem_req.data;
        if (write_mode_sel == 2'b00 || write_mode_sel == 2'b11)
        begin
            rotated = 8'((({mem_req.data, mem_req.data}) >> rotate_count));
        end
    end

    // four identical map lanes
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_lane
            gdp_map_lane u_lane
            (
                .write_mode_sel(write_mode_sel),
                .logic_function(logic_function),
                .fill_bit(fill_q[gi]),
                .fill_en(fen_q[gi] && write_mode_sel == 2'b00),
                .write_bit_mask_value(bmask_q),
                .rotated(rotated),
                .cpu_bit(mem_req.data[gi]),
                .latch(lat_q[gi]),
                .result(lane_out[gi])
            );
        end
    endgenerate

    // write enables: odd/even steers by a0
    always_comb
    begin
        vm_wdata = lane_out;
        vm_we = 4'h0;
        vm_rd = mem_hit && mem_req.rd;
        if (mem_hit && mem_req.wr)
        begin
            vm_we = 4'hF;
            if (chain_odd_even)
            begin
                vm_we = off[0] ? 4'hA : 4'h5;
            end
            else if (chain_four)
            begin
                vm_we = 4'(4'h1 << off[1:0]);
            end
        end
    end

    // colour compare of eight pixels
    always_comb
    begin
        for (int p = 0; p < 8; p++)
        begin
            cmp_byte[p] = ((({vm_rdata[3][p], vm_rdata[2][p], vm_rdata[1][p], vm_rdata[0][p]}
                ^ cmp_q) & ign_q) == 4'h0);
        end
    end

    // register file and latch next values
    always_comb
    begin
        idx_d = idx_q;
        fill_d = fill_q;
        fen_d = fen_q;
        cmp_d = cmp_q;
        rot_d = rot_q;
        rdmap_d = rdmap_q;
        mode_d = mode_q;
        misc_d = misc_q;
        ign_d = ign_q;
        bmask_d = bmask_q;
        lat_d = lat_q;
        rdat_d = rdat_q;
        rsel_d = rsel_q;
        iodat_d = iodat_q;
        if (io_req.wr && io_req.addr == `GDP_PORT_INDEX)
        begin
            idx_d = io_req.data[3:0];
        end
        else if (io_req.wr && io_req.addr == `GDP_PORT_DATA)
        begin
            unique case (idx_q)
                `GDP_IDX_FILL: fill_d = io_req.data[3:0];
                `GDP_IDX_FILL_EN: fen_d = io_req.data[3:0];
                `GDP_IDX_CMP: cmp_d = io_req.data[3:0];
                `GDP_IDX_ROT: rot_d = {3'b000, io_req.data[4:0]};
                `GDP_IDX_RDMAP: rdmap_d = io_req.data[1:0];
                `GDP_IDX_MODE: mode_d = {2'b00, io_req.data[5:3], 1'b0, io_req.data[1:0]};
                `GDP_IDX_MISC: misc_d = {4'h0, io_req.data[3:0]};
                `GDP_IDX_IGN: ign_d = io_req.data[3:0];
                `GDP_IDX_MASK: bmask_d = io_req.data;
                default: ;
            endcase
        end
        // i/o read data, registered
        iodat_d = 8'h00;
        if (io_req.addr == `GDP_PORT_INDEX)
        begin
            iodat_d = {4'h0, idx_q};
        end
        else if (io_req.addr == `GDP_PORT_DATA)
        begin
            unique case (idx_q)
                `GDP_IDX_FILL: iodat_d = {4'h0, fill_q};
                `GDP_IDX_FILL_EN: iodat_d = {4'h0, fen_q};
                `GDP_IDX_CMP: iodat_d = {4'h0, cmp_q};
                `GDP_IDX_ROT: iodat_d = rot_q;
                `GDP_IDX_RDMAP: iodat_d = {6'h00, rdmap_q};
                `GDP_IDX_MODE: iodat_d = mode_q;
                `GDP_IDX_MISC: iodat_d = misc_q;
                `GDP_IDX_IGN: iodat_d = {4'h0, ign_q};
                `GDP_IDX_MASK: iodat_d = bmask_q;
                default: iodat_d = 8'h00;
            endcase
        end
        // map choice captured when the read is issued
        if (vm_rd)
        begin
            rsel_d = chain_four ? off[1:0] : rdmap_q;
        end
        // returned maps refill every latch
        if (vm_rvalid)
        begin
            lat_d = vm_rdata;
            rdat_d = read_mode_sel ? cmp_byte : vm_rdata[rsel_q];
        end
    end

    // state registers; reset values are neutral since none are documented
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            idx_q <= 4'h0;
            fill_q <= 4'h0;
            fen_q <= 4'h0;
            cmp_q <= 4'h0;
            rot_q <= `GDP_RST_BYTE;
            rdmap_q <= 2'b00;
            mode_q <= `GDP_RST_BYTE;
            misc_q <= `GDP_RST_BYTE;
            ign_q <= 4'h0;
            bmask_q <= `GDP_RST_MASK;
            lat_q <= '0;
            rdat_q <= `GDP_RST_BYTE;
            rsel_q <= 2'b00;
            iodat_q <= `GDP_RST_BYTE;
        end
        else
        begin
            idx_q <= idx_d;
            fill_q <= fill_d;
            fen_q <= fen_d;
            cmp_q <= cmp_d;
            rot_q <= rot_d;
            rdmap_q <= rdmap_d;
            mode_q <= mode_d;
            misc_q <= misc_d;
            ign_q <= ign_d;
            bmask_q <= bmask_d;
            lat_q <= lat_d;
            rdat_q <= rdat_d;
            rsel_q <= rsel_d;
            iodat_q <= iodat_d;
        end
    end

    assign io_rdata = iodat_q;
    assign io_hit = io_req.addr == `GDP_PORT_INDEX || io_req.addr == `GDP_PORT_DATA;
    assign mem_rdata = rdat_q;

    // checks
    property p_idx_write;
        @(posedge clk) disable iff (rst)
        io_req.wr && io_req.addr == `GDP_PORT_INDEX |=> idx_q == $past(io_req.data[3:0]);
    endproperty
    a_idx_write: assert property (p_idx_write) else $error("index not taken");
    property p_latch_load;
        @(posedge clk) disable iff (rst) vm_rvalid |=> lat_q == $past(vm_rdata);
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latches not loaded");
    property p_wm1;
        @(posedge clk) disable iff (rst) write_mode_sel == 2'b01 && vm_we != 4'h0 |-> vm_wdata == lat_q;
    endproperty
    a_wm1: assert property (p_wm1) else $error("mode 1 data not latches");
    property p_wm0_fill;
        @(posedge clk) disable iff (rst)
        write_mode_sel == 2'b00 && fen_q[0] && bmask_q == 8'hFF && vm_we[0] |-> vm_wdata[0] == {8{fill_q[0]}}
            || logic_function != 2'b00;
    endproperty
    a_wm0_fill: assert property (p_wm0_fill) else $error("fill not written");
    property p_mask_zero;
        @(posedge clk) disable iff (rst) bmask_q == 8'h00 && write_mode_sel != 2'b01 |-> vm_wdata == lat_q;
    endproperty
    a_mask_zero: assert property (p_mask_zero) else $error("masked bits changed");
    property p_rd0;
        @(posedge clk) disable iff (rst)
        vm_rvalid && !read_mode_sel |=> mem_rdata == $past(vm_rdata[rsel_q]);
    endproperty
    a_rd0: assert property (p_rd0) else $error("wrong map read");
    property p_rd1_ignore;
        @(posedge clk) disable iff (rst) vm_rvalid && read_mode_sel && ign_q == 4'h0 |=> mem_rdata == 8'hFF;
    endproperty
    a_rd1_ignore: assert property (p_rd1_ignore) else $error("ignore not honoured");
    property p_oe_we;
        @(posedge clk) disable iff (rst) chain_odd_even && vm_we != 4'h0 |-> vm_we == (off[0] ? 4'hA : 4'h5);
    endproperty
    a_oe_we: assert property (p_oe_we) else $error("odd/even maps wrong");
    property p_win;
        @(posedge clk) disable iff (rst) memory_window_sel == 2'b11 && mem_req.addr[19:15] != 5'h17 |-> !mem_hit;
    endproperty
    a_win: assert property (p_win) else $error("window decode wrong");
    c_write: cover property (@(posedge clk) disable iff (rst) vm_we == 4'hF);
    c_read1: cover property (@(posedge clk) disable iff (rst) vm_rvalid && read_mode_sel);
    c_wm3: cover property (@(posedge clk) disable iff (rst) write_mode_sel == 2'b11 && vm_we != 4'h0);
endmodule

/* File: gdp_vmem_model.sv */
`timescale 1ns/100ps
// four display maps behind the map port, answering reads after a delay
module gdp_vmem_model
#(
    parameter int LAT = 3 // read answer delay in cycles
)
(
    // clock
    input wire logic clk,
    // map port
    input wire logic [15:0] vm_addr,
    input wire logic [3:0] vm_we,
    input wire gdp_pkg::gdp_maps_t vm_wdata,
    input wire logic vm_rd,
    output gdp_pkg::gdp_maps_t vm_rdata,
    output logic vm_rvalid
);
    import gdp_pkg::*;
    gdp_maps_t mem [0:65535]; // one byte per map per location
    int cnt; // cycles left before the answer
    logic [15:0] ra; // address held for the answer
    // distinct contents per map, so a wrong map choice shows up
    initial
    begin
        cnt = 0;
        ra = 16'h0000;
        vm_rvalid = 1'b0;
        vm_rdata = '0;
        for (int a = 0; a < 65536; a++)
            for (int i = 0; i < 4; i++)
                mem[a][i] = 8'(a + 64 * i);
    end
    // byte writes per map; read answer is a one-cycle pulse
    always @(posedge clk)
    begin
        for (int i = 0; i < 4; i++)
            if (vm_we[i])
                mem[vm_addr][i] <= vm_wdata[i];
        if (vm_rd)
        begin
            cnt <= LAT;
            ra <= vm_addr;
        end
        else if (cnt > 0)
            cnt <= cnt - 1;
        vm_rvalid <= (cnt == 1);
        // no stale data between answers: toggle the bus
        vm_rdata <= (cnt == 1) ? mem[ra] : ~vm_rdata;
    end
endmodule

/* File: gdp_core_tb.sv */
`timescale 1ns/100ps
// register and data path sequences against the map model
module gdp_core_tb;
    import gdp_pkg::*;
    logic clk, rst, io_hit, mem_hit, chain_four, vm_rd, vm_rvalid, graphics_not_text, host_odd_even_mode;
    gdp_io_s io_req; // i/o cycle
    gdp_mem_s mem_req; // memory cycle
    logic [7:0] io_rdata, mem_rdata, v;
    logic [15:0] vm_addr;
    logic [3:0] vm_we;
    gdp_maps_t vm_wdata, vm_rdata;
    int failures, checks_done;
    // field masks of the nine indexed registers
    logic [7:0] msk [9] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03, 8'h3B, 8'h0F, 8'h0F, 8'hFF};
    // map bytes of the fill write, held in the latches once read back
    localparam gdp_maps_t L = 32'h00FF00FF;
    gdp_core uut (.clk(clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata), .io_hit(io_hit),
        .mem_req(mem_req), .mem_hit(mem_hit), .mem_rdata(mem_rdata), .chain_four(chain_four),
        .vm_addr(vm_addr), .vm_we(vm_we), .vm_wdata(vm_wdata), .vm_rd(vm_rd), .vm_rdata(vm_rdata),
        .vm_rvalid(vm_rvalid), .graphics_not_text(graphics_not_text), .host_odd_even_mode(host_odd_even_mode));
    gdp_vmem_model #(.LAT(3)) u_mem (.clk(clk), .vm_addr(vm_addr), .vm_we(vm_we), .vm_wdata(vm_wdata),
        .vm_rd(vm_rd), .vm_rdata(vm_rdata), .vm_rvalid(vm_rvalid));
    // free-running clock, 20 ns
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task end_sim;
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cmp8(input logic [7:0] g, input logic [7:0] e, input string m);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h", $time, m, g);
        end
    endtask
    task cmp32(input gdp_maps_t g, input gdp_maps_t e, input string m);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value at %0t: %s got %h", $time, m, g);
        end
    endtask
    // inputs move 1 ns after the edge
    task step;
        @(posedge clk);
        #1;
    endtask
    // each access is followed by an idle cycle
    task io_wr(input logic [15:0] a, input logic [7:0] d);
        io_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        step;
        io_req = '0;
        step;
    endtask
    task set_reg(input logic [3:0] i, input logic [7:0] d);
        io_wr(16'h03CE, {4'h0, i});
        io_wr(16'h03CF, d);
    endtask
    task rd_reg(input logic [3:0] i, output logic [7:0] d);
        io_wr(16'h03CE, {4'h0, i});
        io_req = '{wr: 1'b0, rd: 1'b1, addr: 16'h03CF, data: 8'h00};
        step;
        d = io_rdata;
        io_req = '0;
        step;
    endtask
    // write cycle: map port is checked in the request cycle
    task mem_wr(input logic [19:0] a, input logic [7:0] d, input gdp_maps_t e, input logic [3:0] we);
        mem_req = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        #1;
        cmp32(vm_wdata, e, "map write data");
        cmp8({4'h0, vm_we}, {4'h0, we}, "map enables");
        step;
        mem_req = '0;
        step;
    endtask
    // read cycle: wait for the maps, result one cycle later
    task mem_rd(input logic [19:0] a, output logic [7:0] d);
        int n;
        mem_req = '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        step;
        mem_req = '0;
        n = 0;
        while (vm_rvalid !== 1'b1 && n < 20)
        begin
            step;
            n++;
        end
        if (n >= 20)
        begin
            failures++;
            end_sim;
        end
        step;
        d = mem_rdata;
        step;
    endtask
    // expected map bytes: function against latches, then bit mask
    function automatic gdp_maps_t exp_all(input logic [1:0] fn, input gdp_maps_t d, input logic [7:0] m);
        gdp_maps_t r;
        logic [7:0] t;
        for (int i = 0; i < 4; i++)
        begin
            case (fn)
                2'b00: t = d[i];
                2'b01: t = d[i] & L[i];
                2'b10: t = d[i] | L[i];
                default: t = d[i] ^ L[i];
            endcase
            r[i] = (t & m) | (L[i] & ~m);
        end
        return r;
    endfunction
    logic [2:0] hit_t [4] = '{3'b111, 3'b100, 3'b010, 3'b001}; // window hits at A0000, B0000, B8000
    logic [19:0] win_a [3] = '{20'hA0000, 20'hB0000, 20'hB8000};
    logic [15:0] rm1_t [4] = '{16'h5FFF, 16'h4F00, 16'h4AFF, 16'h00FF}; // compare, ignore, result
    // main sequence
    initial
    begin
        failures = 0;
        checks_done = 0;
        rst = 1'b1;
        chain_four = 1'b0;
        io_req = '0;
        mem_req = '0;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        step;
        rd_reg(4'h8, v);
        cmp8(v, 8'hFF, "mask reset");
        for (int i = 0; i < 9; i++)
        begin
            set_reg(4'(i), 8'hA5 & msk[i]);
            rd_reg(4'(i), v);
            cmp8(v, 8'hA5 & msk[i], "register readback");
        end
        set_reg(4'h9, 8'hAA);
        rd_reg(4'h9, v);
        cmp8(v, 8'h00, "index beyond table");
        io_req = '{wr: 1'b0, rd: 1'b0, addr: 16'h03CF, data: 8'h00};
        #1;
        cmp8({7'h0, io_hit}, 8'h01, "data port decode");
        step;
        io_req = '{wr: 1'b0, rd: 1'b0, addr: 16'h03CD, data: 8'h00};
        #1;
        cmp8({7'h0, io_hit}, 8'h00, "foreign port decode");
        step;
        io_req = '0;
        step;
        set_reg(4'h6, 8'h00);
        set_reg(4'h5, 8'h00);
        set_reg(4'h3, 8'h00);
        set_reg(4'h8, 8'hFF);
        set_reg(4'h0, 8'h05);
        set_reg(4'h1, 8'h0F);
        mem_wr(20'hA0010, 8'h3C, L, 4'hF);
        for (int p = 0; p < 4; p++)
        begin
            set_reg(4'h4, 8'(p));
            mem_rd(20'hA0010, v);
            cmp8(v, (p % 2 == 0) ? 8'hFF : 8'h00, "read map select");
        end
        set_reg(4'h5, 8'h08);
        foreach (rm1_t[k])
        begin
            set_reg(4'h2, {4'h0, rm1_t[k][15:12]});
            set_reg(4'h7, {4'h0, rm1_t[k][11:8]});
            mem_rd(20'hA0010, v);
            cmp8(v, rm1_t[k][7:0], "colour compare");
        end
        set_reg(4'h5, 8'h00);
        set_reg(4'h1, 8'h00);
        set_reg(4'h8, 8'h0F);
        for (int f = 0; f < 4; f++)
        begin
            set_reg(4'h3, {3'h0, 2'(f), 3'h3});
            mem_wr(20'hA0030, 8'h96, exp_all(2'(f), {4{8'hD2}}, 8'h0F), 4'hF);
        end
        set_reg(4'h8, 8'h00);
        mem_wr(20'hA0030, 8'h96, L, 4'hF);
        set_reg(4'h1, 8'h0F);
        set_reg(4'h5, 8'h01);
        mem_wr(20'hA0030, 8'h96, L, 4'hF);
        set_reg(4'h5, 8'h02);
        set_reg(4'h8, 8'hF0);
        mem_wr(20'hA0030, 8'h0A, exp_all(2'b11, 32'hFF00FF00, 8'hF0), 4'hF);
        set_reg(4'h0, 8'h0A);
        set_reg(4'h5, 8'h03);
        mem_wr(20'hA0030, 8'h96, exp_all(2'b11, 32'hFF00FF00, 8'hD0), 4'hF);
        set_reg(4'h6, 8'h01);
        cmp8({7'h0, graphics_not_text}, 8'h01, "graphics mode");
        set_reg(4'h6, 8'h00);
        cmp8({7'h0, graphics_not_text}, 8'h00, "text mode");
        set_reg(4'h5, 8'h10);
        cmp8({7'h0, host_odd_even_mode}, 8'h01, "host odd/even");
        for (int w = 0; w < 4; w++)
        begin
            set_reg(4'h6, {4'h0, 2'(w), 2'b00});
            for (int k = 0; k < 3; k++)
            begin
                mem_req = '{wr: 1'b0, rd: 1'b0, addr: win_a[k], data: 8'h00};
                #1;
                cmp8({7'h0, mem_hit}, {7'h0, hit_t[w][2 - k]}, "window decode");
                step;
            end
            mem_req = '0;
            step;
        end
        set_reg(4'h5, 8'h00);
        set_reg(4'h8, 8'hFF);
        set_reg(4'h3, 8'h00);
        set_reg(4'h6, 8'h06);
        mem_wr(20'hA0000, 8'h00, 32'hFF00FF00, 4'b0101);
        mem_wr(20'hA0001, 8'h00, 32'hFF00FF00, 4'b1010);
        set_reg(4'h6, 8'h00);
        set_reg(4'h4, 8'h00);
        chain_four = 1'b1;
        for (int p = 0; p < 4; p++)
        begin
            mem_rd(20'hA0020 + 20'(p), v);
            cmp8(v, 8'(8'h08 + 8'(64 * p)), "chained map read");
        end
        chain_four = 1'b0;
        end_sim;
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim;
    end
endmodule
